/* File: logic/scm_pkg.sv */
// Constants, types and carriers shared by the system clock mode control block
package scm_pkg;

    // ------------------------------------------------------------
    // Register indices on the plain register port
    // ------------------------------------------------------------
    localparam logic [1:0] SCM_ADDR_MODE = 2'h0; // Clock mode register
    localparam logic [1:0] SCM_ADDR_CTRL = 2'h1; // Idle system clock keep flag
    localparam logic [1:0] SCM_ADDR_STAT = 2'h2; // Sticky event status
    localparam logic [1:0] SCM_ADDR_MASK = 2'h3; // Event mask

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int SCM_MODE_HSEL = 0; // High clock select
    localparam int SCM_MODE_IDLE = 1; // Idle on halt
    localparam int SCM_MODE_HRDY = 2; // High oscillator ready
    localparam int SCM_MODE_LRDY = 3; // Low oscillator ready
    localparam int SCM_MODE_FAST = 4; // Fast wake-up enable
    localparam int SCM_MODE_DIVL = 5; // Divider select low bit
    localparam int SCM_MODE_DIVH = 7; // Divider select high bit
    localparam int SCM_CTRL_KEEP = 7; // Idle system clock keep
    localparam logic [7:0] SCM_MODE_RST = 8'h03; // Idle on halt, high clock
    localparam logic [7:0] SCM_MODE_WMASK = 8'hf3; // Writable mode bits
    localparam logic [6:0] SCM_CTRL_ZERO = 7'h00; // Low control bits read zero
    localparam logic SCM_CTRL_KEEP_RST = 1'b0; // Keep bit after reset

    // ------------------------------------------------------------
    // Divider select encoding
    // ------------------------------------------------------------
    localparam logic [2:0] SCM_DIV_SUB_MAX = 3'h1; // Codes up to this give sub clock
    localparam logic [3:0] SCM_DIV_EXP_BASE = 4'h8; // Exponent is base minus code
    localparam logic [5:0] SCM_DIV_ONES = 6'h3f; // Divider counter full mask

    // ------------------------------------------------------------
    // Stabilisation and wake-up counts, in oscillator cycles, the resume count in system cycles
    // ------------------------------------------------------------
    localparam int SCM_CNT_W = 11; // Ready counter width
    localparam logic [SCM_CNT_W-1:0] SCM_XTAL_CYC = 11'h400; // Crystal start, 1024
    localparam logic [SCM_CNT_W-1:0] SCM_HRC_CYC = 11'h010; // High RC start, 16
    localparam logic [SCM_CNT_W-1:0] SCM_LRC_CYC = 11'h002; // Low RC start, 2
    localparam logic [1:0] SCM_RESUME_CYC = 2'h2; // Resume from running pause
    localparam logic [1:0] SCM_FAST_CYC = 2'h2; // Sub cycles before fast run

    // ------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------
    localparam int SCM_IRQ_W = 3; // Number of events
    localparam int SCM_EV_HRDY = 0; // High oscillator became ready
    localparam int SCM_EV_LRDY = 1; // Low oscillator became ready
    localparam int SCM_EV_WAKE = 2; // CPU resumed after wake-up

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SCM_ST_RUN = 3'h0,        // Normal or slow running
        SCM_ST_PAUSE_RUN = 3'h1,  // Clock running pause
        SCM_ST_PAUSE_STOP = 3'h2, // Clock stopped pause
        SCM_ST_SUB_STOP = 3'h3,   // Sub running stop state
        SCM_ST_FULL_STOP = 3'h4,  // Full stop state
        SCM_ST_WAKE_WAIT = 3'h5,  // Waiting for the oscillator, or for the resume count after running pause
        SCM_ST_FAST_RUN = 3'h6    // Running on sub clock temporarily
    } scm_state_t;

    typedef enum logic [1:0] {
        SCM_SRC_HIGH = 2'h0, // Undivided high-speed clock
        SCM_SRC_DIV = 2'h1,  // Divided high-speed clock
        SCM_SRC_SUB = 2'h2,  // Sub clock
        SCM_SRC_NONE = 2'h3  // System clock stopped
    } scm_src_t;

    typedef struct packed {
        logic high_is_crystal; // High oscillator is the external crystal
        logic low_is_crystal;  // Sub clock is the external crystal
        logic sub_keep;        // Watchdog, detector or display needs sub clock
    } scm_osc_cfg_t;

    typedef struct packed {
        logic cpu_run;     // CPU clock enabled
        logic sysclk_run;  // System clock to peripherals enabled
        logic high_osc_en; // High-speed oscillator enable
        logic sub_osc_en;  // Sub oscillator enable
        scm_src_t src;     // System clock source
    } scm_clk_ctl_t;

endpackage

/* File: logic/scm_system_clock_mode_control.sv */
// System clock selection, halt modes, oscillator ready tracking and fast wake-up
`timescale 1ns/1ps

module scm_system_clock_mode_control
    import scm_pkg::*;
(
    input wire logic core_clk_i,             // Block clock, 40 MHz
    input wire logic sys_rst_i,              // Synchronous reset, high
    input wire logic ce_i,                   // Clock enable, low freezes
    input wire logic [1:0] reg_addr_i,       // Register index
    input wire logic [7:0] reg_wdata_i,      // Write data
    input wire logic reg_wr_i,               // Write strobe
    input wire logic reg_rd_i,               // Read strobe
    output logic [7:0] reg_rdata_o,          // Read data, one cycle later
    input wire scm_osc_cfg_t osc_cfg_i,      // Oscillator configuration
    input wire logic high_tick_i,            // One pulse per high oscillator cycle
    input wire logic sub_tick_i,             // One pulse per sub oscillator cycle
    input wire logic halt_i,                 // Halt instruction pulse
    input wire logic wake_i,                 // Wake-up event pulse
    output scm_clk_ctl_t clk_ctl_o,          // Clock controls
    output logic sys_tick_o,                 // One pulse per system clock cycle
    output scm_state_t state_o,              // Current operating state
    output logic irq_o                       // Level interrupt
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] mode_reg;                    // Mode register storage
    logic keep_reg;                          // Idle system clock keep
    logic [SCM_IRQ_W-1:0] stat_reg;          // Sticky events
    logic [SCM_IRQ_W-1:0] mask_reg;          // Event mask
    logic [7:0] rdata_reg;                   // Read data
    scm_state_t state_reg;                   // Operating state
    scm_state_t state_next;                  // Next operating state
    logic from_run_reg;                      // Wake began from running pause
    logic [1:0] wake_cnt_reg;                // Wake-up cycle count
    logic [SCM_CNT_W-1:0] hcnt_reg;          // High oscillator start count
    logic [SCM_CNT_W-1:0] lcnt_reg;          // Sub oscillator start count
    logic hrdy_reg;                          // High oscillator ready
    logic lrdy_reg;                          // Low oscillator ready
    logic cpu_prev_reg;                      // CPU run last cycle
    logic [5:0] div_cnt_reg;                 // High clock divider
    logic sys_tick_reg;                      // System tick output

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    wire [2:0] div_sel = mode_reg[SCM_MODE_DIVH:SCM_MODE_DIVL]; // Divider code
    wire fast_en = mode_reg[SCM_MODE_FAST];  // Fast wake-up request
    wire idle_on_halt = mode_reg[SCM_MODE_IDLE]; // Halt goes to pause
    wire high_sel = mode_reg[SCM_MODE_HSEL]; // Undivided high clock
    wire on_high = high_sel | (div_sel > SCM_DIV_SUB_MAX);

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    wire wr_mode = reg_wr_i & (reg_addr_i == SCM_ADDR_MODE); // Mode write
    wire wr_ctrl = reg_wr_i & (reg_addr_i == SCM_ADDR_CTRL); // Control write
    wire wr_stat = reg_wr_i & (reg_addr_i == SCM_ADDR_STAT); // Status clear
    wire wr_mask = reg_wr_i & (reg_addr_i == SCM_ADDR_MASK); // Mask write
    // Ready bits are hardware owned, so writes there are dropped
    wire [7:0] mode_next = (reg_wdata_i & SCM_MODE_WMASK) | (mode_reg & ~SCM_MODE_WMASK);
    wire [7:0] mode_view = {mode_reg[SCM_MODE_DIVH:SCM_MODE_FAST], lrdy_reg, hrdy_reg,
                            mode_reg[SCM_MODE_IDLE:SCM_MODE_HSEL]}; // Mode as read
    wire [7:0] ctrl_view = {keep_reg, SCM_CTRL_ZERO};
    wire [7:0] stat_view = {{(8 - SCM_IRQ_W){1'b0}}, stat_reg}; // Status as read
    wire [7:0] mask_view = {{(8 - SCM_IRQ_W){1'b0}}, mask_reg}; // Mask as read
    wire [7:0] rdata_next = (reg_addr_i == SCM_ADDR_MODE) ? mode_view :
                            (reg_addr_i == SCM_ADDR_CTRL) ? ctrl_view :
                            (reg_addr_i == SCM_ADDR_STAT) ? stat_view : mask_view;

    // ------------------------------------------------------------
    // Wake-up decisions
    // ------------------------------------------------------------
    wire in_stop = (state_reg == SCM_ST_PAUSE_STOP) | (state_reg == SCM_ST_SUB_STOP) |
                   (state_reg == SCM_ST_FULL_STOP); // Oscillator stopped
    // Fast path only for the high crystal and only with the sub clock alive
    wire fast_ok = on_high & osc_cfg_i.high_is_crystal & fast_en &
                   (state_reg != SCM_ST_FULL_STOP);
    wire fast_live = wake_cnt_reg == SCM_FAST_CYC;
    wire resumed = wake_cnt_reg == SCM_RESUME_CYC;
    wire osc_ready = on_high ? hrdy_reg : lrdy_reg;
    wire wait_done = from_run_reg ? resumed : osc_ready; // Wake wait exit
    wire [SCM_CNT_W-1:0] htarget = osc_cfg_i.high_is_crystal ? SCM_XTAL_CYC : SCM_HRC_CYC;
    wire [SCM_CNT_W-1:0] ltarget = osc_cfg_i.low_is_crystal ? SCM_XTAL_CYC : SCM_LRC_CYC;

    // ------------------------------------------------------------
    // Operating state transitions
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SCM_ST_RUN: begin
                if (halt_i) begin
                    if (idle_on_halt) begin
                        state_next = keep_reg ? SCM_ST_PAUSE_RUN : SCM_ST_PAUSE_STOP;
                    end else begin
                        state_next = osc_cfg_i.sub_keep ? SCM_ST_SUB_STOP : SCM_ST_FULL_STOP;
                    end
                end
            end
            SCM_ST_PAUSE_RUN: begin
                if (wake_i) begin
                    state_next = SCM_ST_WAKE_WAIT;
                end
            end
            SCM_ST_PAUSE_STOP, SCM_ST_SUB_STOP, SCM_ST_FULL_STOP: begin
                if (wake_i) begin
                    state_next = fast_ok ? SCM_ST_FAST_RUN : SCM_ST_WAKE_WAIT;
                end
            end
            SCM_ST_WAKE_WAIT: begin
                if (wait_done) begin
                    state_next = SCM_ST_RUN;
                end
            end
            SCM_ST_FAST_RUN: begin
                // Software may have moved to the sub clock meanwhile
                if (hrdy_reg | ~on_high) begin
                    state_next = SCM_ST_RUN;
                end
            end
            default: begin
                state_next = SCM_ST_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Clock controls
    // ------------------------------------------------------------
    wire in_fast = state_reg == SCM_ST_FAST_RUN; // Temporary sub clock
    wire cpu_run = (state_reg == SCM_ST_RUN) | (in_fast & fast_live); // CPU clock
    wire sys_run = (state_reg == SCM_ST_RUN) | (state_reg == SCM_ST_PAUSE_RUN) | in_fast |
                   ((state_reg == SCM_ST_WAKE_WAIT) & from_run_reg);
    // High oscillator off when sub is the source outside fast run, and in the three stop states
    wire high_en = (on_high & ~in_stop) | in_fast;
    wire sub_en = state_reg != SCM_ST_FULL_STOP;
    wire scm_src_t src_sel = ~sys_run ? SCM_SRC_NONE :
                             in_fast ? SCM_SRC_SUB :
                             high_sel ? SCM_SRC_HIGH :
                             on_high ? SCM_SRC_DIV : SCM_SRC_SUB;

    // ------------------------------------------------------------
    // High clock divider
    // ------------------------------------------------------------
    wire [3:0] div_exp = SCM_DIV_EXP_BASE - {1'b0, div_sel}; // Code 2 gives 6
    wire [5:0] div_hi = SCM_DIV_ONES << div_exp; // Bits above the ratio
    wire [5:0] div_mask = ~div_hi; // Ratio minus one
    wire div_wrap = (div_cnt_reg & div_mask) == div_mask; // Last cycle of ratio
    wire tick_next = (src_sel == SCM_SRC_HIGH) ? high_tick_i :
                     (src_sel == SCM_SRC_DIV) ? (high_tick_i & div_wrap) :
                     (src_sel == SCM_SRC_SUB) ? sub_tick_i : 1'b0;

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    wire hrdy_set = high_en & ~hrdy_reg & high_tick_i & (hcnt_reg + 11'h001 == htarget);
    wire lrdy_set = sub_en & ~lrdy_reg & sub_tick_i & (lcnt_reg + 11'h001 == ltarget);
    wire [SCM_IRQ_W-1:0] events; // Event pulses
    assign events[SCM_EV_HRDY] = hrdy_set;
    assign events[SCM_EV_LRDY] = lrdy_set;
    assign events[SCM_EV_WAKE] = cpu_run & ~cpu_prev_reg;
    wire [SCM_IRQ_W-1:0] clr_bits = wr_stat ? reg_wdata_i[SCM_IRQ_W-1:0] : '0; // W1C
    // A set in the same cycle as its clear is kept
    wire [SCM_IRQ_W-1:0] stat_next = (stat_reg & ~clr_bits) | events;

    // ------------------------------------------------------------
    // Software registers and read data
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            mode_reg <= SCM_MODE_RST;
            keep_reg <= SCM_CTRL_KEEP_RST;
            stat_reg <= '0;
            mask_reg <= '0;
            rdata_reg <= 8'h00;
        end else if (ce_i) begin
            if (wr_mode) begin
                mode_reg <= mode_next;
            end
            if (wr_ctrl) begin
                keep_reg <= reg_wdata_i[SCM_CTRL_KEEP];
            end
            if (wr_mask) begin
                mask_reg <= reg_wdata_i[SCM_IRQ_W-1:0];
            end
            stat_reg <= stat_next;
            if (reg_rd_i) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // ------------------------------------------------------------
    // State and wake-up counting
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_reg <= SCM_ST_RUN;
            from_run_reg <= 1'b0;
            wake_cnt_reg <= 2'h0;
            cpu_prev_reg <= 1'b1;
        end else if (ce_i) begin
            state_reg <= state_next;
            cpu_prev_reg <= cpu_run;
            if (wake_i & (state_reg == SCM_ST_PAUSE_RUN)) begin
                from_run_reg <= 1'b1;
            end else if (state_reg == SCM_ST_RUN) begin
                from_run_reg <= 1'b0;
            end
            // Running pause counts system cycles, fast path counts sub cycles
            if ((state_reg == SCM_ST_WAKE_WAIT) & from_run_reg & sys_tick_reg & ~resumed) begin
                wake_cnt_reg <= wake_cnt_reg + 2'h1;
            end else if (in_fast & sub_tick_i & ~fast_live) begin
                wake_cnt_reg <= wake_cnt_reg + 2'h1;
            end else if (state_reg == SCM_ST_RUN) begin
                wake_cnt_reg <= 2'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Oscillator ready tracking
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            hcnt_reg <= '0;
            lcnt_reg <= '0;
            hrdy_reg <= 1'b0;
            lrdy_reg <= 1'b0;
        end else if (ce_i) begin
            // A stopped oscillator loses its ready state and restarts counting
            if (~high_en) begin
                hcnt_reg <= '0;
                hrdy_reg <= 1'b0;
            end else if (high_tick_i & ~hrdy_reg) begin
                hcnt_reg <= hcnt_reg + 11'h001;
                hrdy_reg <= hrdy_set;
            end
            if (~sub_en) begin
                lcnt_reg <= '0;
                lrdy_reg <= 1'b0;
            end else if (sub_tick_i & ~lrdy_reg) begin
                lcnt_reg <= lcnt_reg + 11'h001;
                lrdy_reg <= lrdy_set;
            end
        end
    end

    // ------------------------------------------------------------
    // Divider and system tick
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            div_cnt_reg <= 6'h00;
            sys_tick_reg <= 1'b0;
        end else if (ce_i) begin
            if (~high_en) begin
                div_cnt_reg <= 6'h00;
            end else if (high_tick_i) begin
                div_cnt_reg <= div_cnt_reg + 6'h01;
            end
            sys_tick_reg <= tick_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata_o = rdata_reg;
    assign clk_ctl_o.cpu_run = cpu_run;
    assign clk_ctl_o.sysclk_run = sys_run;
    assign clk_ctl_o.high_osc_en = high_en;
    assign clk_ctl_o.sub_osc_en = sub_en;
    assign clk_ctl_o.src = src_sel;
    assign sys_tick_o = sys_tick_reg;
    assign state_o = state_reg;
    assign irq_o = |(stat_reg & mask_reg);

endmodule // scm_system_clock_mode_control

/* File: bench/scm_system_clock_mode_control_chk.sv */
// Concurrent checks on the clock mode control ports
`timescale 1ns/1ps
module scm_system_clock_mode_control_chk
    import scm_pkg::*;
(
    input wire logic core_clk_i,       // Block clock
    input wire logic sys_rst_i,        // Synchronous reset
    input wire logic halt_i,           // Halt pulse
    input wire logic wake_i,           // Wake pulse
    input wire scm_clk_ctl_t clk_ctl_o, // Clock controls
    input wire scm_state_t state_o     // Operating state
);
    // ------------------------------------------------------------
    // One domain, so one clocking and one disable
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_sub_high_off: assert property (clk_ctl_o.src == SCM_SRC_SUB && state_o != SCM_ST_FAST_RUN |-> !clk_ctl_o.high_osc_en)
        else $error("high oscillator left on while running from sub clock");
    a_halt_stops_cpu: assert property (halt_i && state_o == SCM_ST_RUN |=> !clk_ctl_o.cpu_run)
        else $error("cpu still clocked after halt");
    a_pause_run_clk: assert property (state_o == SCM_ST_PAUSE_RUN |-> clk_ctl_o.sysclk_run && !clk_ctl_o.cpu_run)
        else $error("running pause has wrong clock enables");
    a_pause_stop_clk: assert property (state_o == SCM_ST_PAUSE_STOP |-> !clk_ctl_o.sysclk_run && !clk_ctl_o.cpu_run)
        else $error("stopped pause still clocks the system");
    a_stop_high_off: assert property (state_o inside {SCM_ST_PAUSE_STOP, SCM_ST_SUB_STOP, SCM_ST_FULL_STOP}
        |-> !clk_ctl_o.high_osc_en)
        else $error("high oscillator running in a stopped state");
    a_full_stop_sub: assert property (state_o == SCM_ST_FULL_STOP |-> !clk_ctl_o.sub_osc_en)
        else $error("sub oscillator running in full stop");
    a_no_fast_full: assert property (state_o == SCM_ST_FULL_STOP && wake_i |=> state_o != SCM_ST_FAST_RUN)
        else $error("fast wake-up taken from full stop");
    a_resume_quick: assert property (state_o == SCM_ST_PAUSE_RUN && wake_i |=> ##[0:200] state_o == SCM_ST_RUN)
        else $error("running pause did not resume in time");
    a_fast_on_sub: assert property (state_o == SCM_ST_FAST_RUN |-> clk_ctl_o.src == SCM_SRC_SUB)
        else $error("fast run not on sub clock");

    // Main scenarios reached
    c_pause_run: cover property (state_o == SCM_ST_PAUSE_RUN);
    c_fast_run: cover property (state_o == SCM_ST_FAST_RUN);
    c_full_stop: cover property (state_o == SCM_ST_FULL_STOP);
endmodule // scm_system_clock_mode_control_chk

bind scm_system_clock_mode_control scm_system_clock_mode_control_chk u_chk (.core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i), .halt_i(halt_i), .wake_i(wake_i), .clk_ctl_o(clk_ctl_o), .state_o(state_o));

/* File: bench/tb_scm_system_clock_mode_control.sv */
// Directed register and power-state bench for the clock mode control block
`timescale 1ns/1ps
module tb_scm_system_clock_mode_control;
    import scm_pkg::*;
    logic core_clk_i = 1'h0;      // 40 MHz clock
    logic sys_rst_i = 1'h1;       // Reset
    logic ce_i = 1'h1;            // Always enabled
    logic [1:0] reg_addr_i = 2'h0; // Register index
    logic [7:0] reg_wdata_i = 8'h00; // Write data
    logic reg_wr_i = 1'h0;        // Write strobe
    logic reg_rd_i = 1'h0;        // Read strobe
    logic [7:0] reg_rdata_o;      // Read data
    scm_osc_cfg_t osc_cfg_i = '0; // RC oscillators
    logic high_tick_i = 1'h1;     // High oscillator at full rate
    logic sub_tick_i = 1'h0;      // Sub oscillator, one in four
    logic halt_i = 1'h0;          // Halt pulse
    logic wake_i = 1'h0;          // Wake pulse
    scm_clk_ctl_t clk_ctl_o;      // Clock controls
    logic sys_tick_o;             // System tick
    scm_state_t state_o;          // State
    logic irq_o;                  // Interrupt
    logic [1:0] sub_div = 2'h0;   // Sub prescaler
    logic [7:0] rd_val;           // Last read value
    int error_cnt = 0;
    int n_checks = 0;
    int n;
    int cnt;

    always #12.5 core_clk_i = ~core_clk_i;
    // Sub clock at a quarter of the high rate, so only divider code 6 gives the same rate
    always @(posedge core_clk_i) begin
        sub_div <= sub_div + 2'h1;
        sub_tick_i <= (sub_div == 2'h3);
    end

    scm_system_clock_mode_control dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .osc_cfg_i(osc_cfg_i), .high_tick_i(high_tick_i), .sub_tick_i(sub_tick_i),
        .halt_i(halt_i), .wake_i(wake_i), .clk_ctl_o(clk_ctl_o), .sys_tick_o(sys_tick_o), .state_o(state_o),
        .irq_o(irq_o));

    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic final_report;
        if (error_cnt == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk_i) begin reg_wr_i <= 1'h1; reg_addr_i <= a; reg_wdata_i <= d; end
        @(posedge core_clk_i) reg_wr_i <= 1'h0;
    endtask
    // Data stand from the cycle after the strobe until the next read
    task automatic rd(input logic [1:0] a);
        @(posedge core_clk_i) begin reg_rd_i <= 1'h1; reg_addr_i <= a; end
        @(posedge core_clk_i) reg_rd_i <= 1'h0;
        #1 rd_val = reg_rdata_o;
    endtask
    task automatic pulse(input logic is_wake);
        @(posedge core_clk_i) begin wake_i <= is_wake; halt_i <= !is_wake; end
        @(posedge core_clk_i) begin wake_i <= 1'h0; halt_i <= 1'h0; end
        #1;
    endtask
    // Bounded wait for the run state; n holds cycles taken
    task automatic wait_run(input int hi);
        n = 0;
        while (state_o !== SCM_ST_RUN) begin
            if (n >= hi) begin error_cnt++; final_report; end
            @(posedge core_clk_i) #1 n++;
        end
    endtask
    task automatic count_ticks;
        cnt = 0;
        repeat (256) @(posedge core_clk_i) #1 cnt += (sys_tick_o === 1'h1);
    endtask
    task automatic sleep_wake(input logic [7:0] mode, input scm_osc_cfg_t cfg, input logic keep,
        input scm_state_t s_sleep, input logic [1:0] rdy, input scm_state_t s_wake, input int lo, input int hi);
        // Oscillator straps change on the edge, like every other input
        @(posedge core_clk_i) osc_cfg_i <= cfg;
        wr(SCM_ADDR_MODE, mode);
        wr(SCM_ADDR_CTRL, {keep, 7'h00});
        repeat (20) @(posedge core_clk_i);
        pulse(1'h0);
        check(state_o, s_sleep, "sleep state");
        rd(SCM_ADDR_MODE);
        check(rd_val[3:2], rdy, "ready flags");
        pulse(1'h1);
        check(state_o, s_wake, "wake state");
        wait_run(hi);
        check(n >= lo, 1, "wake time");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge core_clk_i);
        sys_rst_i <= 1'h0;
        rd(SCM_ADDR_MODE);
        check(rd_val, SCM_MODE_RST, "mode reset");
        wr(SCM_ADDR_CTRL, 8'h7f);
        rd(SCM_ADDR_CTRL);
        check(rd_val, 8'h00, "ctrl unused bits");
        repeat (40) @(posedge core_clk_i);
        rd(SCM_ADDR_MODE);
        check(rd_val, 8'h0f, "ready after start");
        // Ready events latch and raise the interrupt once unmasked
        rd(SCM_ADDR_STAT);
        check(rd_val, 8'h03, "status");
        wr(SCM_ADDR_MASK, 8'h07);
        #1 check(irq_o, 1'h1, "irq set");
        wr(SCM_ADDR_STAT, 8'h03);
        #1 check(irq_o, 1'h0, "irq clear");
        wr(SCM_ADDR_MASK, 8'h00);
        // Every divider code, ending on sub clock
        for (int c = 7; c >= 0; c--) begin
            wr(SCM_ADDR_MODE, {c[2:0], 5'h02});
            repeat (40) @(posedge core_clk_i);
            count_ticks;
            n = (c < 2) ? 64 : (256 >> (8 - c));
            check(clk_ctl_o.src, (c < 2) ? SCM_SRC_SUB : SCM_SRC_DIV, "source");
            check(cnt >= n - 1 && cnt <= n + 1, 1, "tick count");
        end
        check(clk_ctl_o.high_osc_en, 1'h0, "high osc off");
        wr(SCM_ADDR_MODE, 8'h03);
        repeat (40) @(posedge core_clk_i);
        count_ticks;
        check(clk_ctl_o.src, SCM_SRC_HIGH, "source high");
        check(cnt >= 255, 1, "undivided ticks");
        // Halt and wake in each state and oscillator kind
        sleep_wake(8'h03, 3'h0, 1'h1, SCM_ST_PAUSE_RUN, 2'h3, SCM_ST_WAKE_WAIT, 1, 8);
        sleep_wake(8'h13, 3'h0, 1'h0, SCM_ST_PAUSE_STOP, 2'h2, SCM_ST_WAKE_WAIT, 14, 40);
        sleep_wake(8'h01, 3'h1, 1'h0, SCM_ST_SUB_STOP, 2'h2, SCM_ST_WAKE_WAIT, 14, 40);
        sleep_wake(8'h01, 3'h0, 1'h0, SCM_ST_FULL_STOP, 2'h0, SCM_ST_WAKE_WAIT, 14, 40);
        sleep_wake(8'h11, 3'h5, 1'h0, SCM_ST_SUB_STOP, 2'h2, SCM_ST_FAST_RUN, 1000, 1100);
        sleep_wake(8'h11, 3'h4, 1'h0, SCM_ST_FULL_STOP, 2'h0, SCM_ST_WAKE_WAIT, 1000, 1100);
        sleep_wake(8'h00, 3'h2, 1'h0, SCM_ST_FULL_STOP, 2'h0, SCM_ST_WAKE_WAIT, 4000, 4300);
        rd(SCM_ADDR_STAT);
        check(rd_val[2], 1'h1, "wake status");
        final_report;
    end
endmodule // tb_scm_system_clock_mode_control
